// >>> rtl/liu_pkg.sv
// Package for the line interface unit control block: register map, field
// positions, reset values, line modes and transmit timing constants.
// Assumes a 10 MHz master clock and an 8-bit register port.
package liu_pkg;
  localparam int ADDR_W = 13;
  typedef logic [ADDR_W-1:0] liu_addr_t;
  // Register offsets
  localparam liu_addr_t A_GXCVR_CTL2 = 13'h00F2;
  localparam liu_addr_t A_GCLK_SEL = 13'h00F3;
  localparam liu_addr_t A_SOFT_RST = 13'h00F5;
  localparam liu_addr_t A_GIRQ_STAT = 13'h00FB;
  localparam liu_addr_t A_GIRQ_MASK = 13'h00FE;
  localparam liu_addr_t A_MODE_CTL = 13'h1000;
  localparam liu_addr_t A_TX_SHAPE = 13'h1001;
  localparam liu_addr_t A_MAINT_CTL = 13'h1002;
  localparam liu_addr_t A_LIVE_STAT = 13'h1003;
  localparam liu_addr_t A_STAT_MASK = 13'h1004;
  localparam liu_addr_t A_LATCH_STAT = 13'h1005;
  localparam liu_addr_t A_RX_LEVEL = 13'h1006;
  localparam liu_addr_t A_RX_IMP_SENS = 13'h1007;
  // line_mode_control fields
  localparam int F_MODE_LO = 0;
  localparam int F_TRISTATE = 2;
  localparam int F_AMI_SEL = 3;
  localparam int F_LOS_LO = 4;
  // line_maintenance_control fields
  localparam int F_TX_AIS = 0;
  localparam int F_AUTO_AIS = 1;
  localparam int F_TX_PDN = 2;
  localparam int F_JA_EN = 3;
  localparam int F_JA_TX = 4;
  // Status bit positions (live, latched and mask share them)
  localparam int S_LOS = 0;
  localparam int S_OPEN = 1;
  localparam int S_SHORT = 2;
  localparam logic [7:0] STAT_USED = 8'h07;
  // Soft reset and global interrupt bit
  localparam int F_LIU_RST = 0;
  localparam int F_LIU_IRQ = 0;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  typedef enum logic [1:0] {
    MODE_T1 = 2'b00,
    MODE_J1 = 2'b01,
    MODE_E1 = 2'b10
  } liu_mode_e;
  // Coded symbol in the substitution pipe
  typedef enum logic [1:0] {
    SYM_SPACE = 2'b00,
    SYM_MARK = 2'b01,
    SYM_VIOL = 2'b10
  } liu_sym_e;
  // Transmit timing: line rates and a 16-bit phase accumulator step
  localparam longint MCLK_HZ = 64'd10000000;
  localparam longint E1_RATE_HZ = 64'd2048000;
  localparam longint T1_RATE_HZ = 64'd1544000;
  localparam logic [15:0] E1_STEP = 16'((E1_RATE_HZ * 64'd65536) / MCLK_HZ);
  localparam logic [15:0] T1_STEP = 16'((T1_RATE_HZ * 64'd65536) / MCLK_HZ);
  typedef struct packed {
    logic pos;
    logic neg;
  } liu_pulse_s;
endpackage

// >>> rtl/liu_ctrl.sv
// Line interface unit control: transmit line coder, jitter attenuator
// path mux, output enable and power-down, fault status and register map.
// Assumes the register strobes and framer/receiver signals share I_MCLK;
// enable pin, fault detectors and level code arrive asynchronously.
`timescale 1ns/100ps
`default_nettype none
module liu_ctrl
  import liu_pkg::*;
(
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // Register port
  input wire liu_pkg::liu_addr_t I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Framer transmit side (internal)
  input wire logic I_TX_NRZ,
  input wire logic I_TX_BIT_EN,
  // Receiver recovered data (internal)
  input wire logic I_RX_DATA,
  input wire logic I_RX_BIT_EN,
  output logic O_RX_DATA,
  output logic O_RX_BIT_EN,
  // Asynchronous line-side inputs
  input wire logic I_TX_OUTPUT_ENABLE_PIN,
  input wire logic I_SHORT_DET,
  input wire logic I_OPEN_DET,
  input wire logic I_RX_LOS,
  input wire logic [3:0] I_RX_LEVEL,
  // Transmit line driver
  output liu_pkg::liu_pulse_s O_TX_PULSE,
  output logic O_TX_OE,
  output logic O_TX_PWR_DN,
  // Analog settings
  output logic [3:0] O_TX_SHAPE,
  output logic [1:0] O_TX_IMPED,
  output logic [7:0] O_RX_CFG,
  // Line interrupt summary
  output logic O_LINE_IRQ
);
  import liu_pkg::*;

  logic [7:0] gxcvr_ff, gclk_ff, mode_ff, shape_ff, maint_ff, mask_ff, latch_ff;
  logic [7:0] rxcfg_ff, gmask_ff, gstat_ff;
  logic soft_rst_ff;
  logic [2:0] ev_meta_ff, ev_ff;
  logic en_meta_ff, en_ff;
  logic [3:0] lvl_meta_ff, lvl_sync_ff, lvl_chk_ff, lvl_ff;
  logic [15:0] acc_ff;
  logic ais_tick_ff;
  logic [1:0] pipe_ff [8];
  logic last_pol_ff, odd_ff;
  liu_pulse_s code_ff, ja_ff;
  logic rx_d_ff, rx_e_ff;

  function automatic logic hit(input liu_addr_t a, input liu_addr_t b);
    hit = (a == b);
  endfunction

  wire wr_latch = I_WR && hit(I_ADDR, A_LATCH_STAT);
  wire [7:0] live = {5'h00, ev_ff};
  wire is_e1 = (mode_ff[F_MODE_LO +: 2] == MODE_E1);
  wire ais = maint_ff[F_TX_AIS] || (maint_ff[F_AUTO_AIS] && ev_ff[S_LOS]);
  wire bit_en = ais ? ais_tick_ff : I_TX_BIT_EN;
  wire bit_in = ais ? 1'b1 : I_TX_NRZ;
  wire ja_tx = maint_ff[F_JA_EN] && maint_ff[F_JA_TX];
  wire ja_rx = maint_ff[F_JA_EN] && !maint_ff[F_JA_TX];

  // Asynchronous inputs: two flops before any logic
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ev_meta_ff <= 3'h0;
      ev_ff <= 3'h0;
      en_meta_ff <= 1'b0;
      en_ff <= 1'b0;
      lvl_meta_ff <= 4'h0;
      lvl_sync_ff <= 4'h0;
      lvl_chk_ff <= 4'h0;
      lvl_ff <= 4'h0;
    end else begin
      ev_meta_ff <= {I_SHORT_DET, I_OPEN_DET, I_RX_LOS};
      ev_ff <= ev_meta_ff;
      en_meta_ff <= I_TX_OUTPUT_ENABLE_PIN;
      en_ff <= en_meta_ff;
      lvl_meta_ff <= I_RX_LEVEL;
      lvl_sync_ff <= lvl_meta_ff;
      lvl_chk_ff <= lvl_sync_ff;
      // A multi-bit code may be caught mid-change; take it once it repeats
      if (lvl_chk_ff == lvl_sync_ff) begin
        lvl_ff <= lvl_chk_ff;
      end
    end
  end

  // Configuration registers; soft reset returns all but gxcvr_ff, gclk_ff and gmask_ff to defaults
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      gxcvr_ff <= RST_ZERO;
      gclk_ff <= RST_ZERO;
      mode_ff <= RST_ZERO;
      shape_ff <= RST_ZERO;
      maint_ff <= RST_ZERO;
      mask_ff <= RST_MASK;
      rxcfg_ff <= RST_ZERO;
      gmask_ff <= RST_MASK;
    end else if (soft_rst_ff) begin
      mode_ff <= RST_ZERO;
      shape_ff <= RST_ZERO;
      maint_ff <= RST_ZERO;
      mask_ff <= RST_MASK;
      rxcfg_ff <= RST_ZERO;
    end else if (I_WR) begin
      if (hit(I_ADDR, A_GXCVR_CTL2)) begin
        gxcvr_ff <= I_WDATA;
      end else if (hit(I_ADDR, A_GCLK_SEL)) begin
        gclk_ff <= I_WDATA;
      end else if (hit(I_ADDR, A_GIRQ_MASK)) begin
        gmask_ff <= I_WDATA;
      end else if (hit(I_ADDR, A_MODE_CTL)) begin
        mode_ff <= I_WDATA;
      end else if (hit(I_ADDR, A_TX_SHAPE)) begin
        shape_ff <= I_WDATA;
      end else if (hit(I_ADDR, A_MAINT_CTL)) begin
        maint_ff <= I_WDATA;
      end else if (hit(I_ADDR, A_STAT_MASK)) begin
        mask_ff <= I_WDATA & STAT_USED;
      end else if (hit(I_ADDR, A_RX_IMP_SENS)) begin
        rxcfg_ff <= I_WDATA;
      end
    end
  end

  // Self-clearing software reset pulse
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= I_WR && hit(I_ADDR, A_SOFT_RST) && I_WDATA[F_LIU_RST];
    end
  end

  // Latched status: a new event wins over a same-cycle clear
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      latch_ff <= RST_ZERO;
    end else if (soft_rst_ff) begin
      latch_ff <= live;
    end else begin
      latch_ff <= (latch_ff & ~(wr_latch ? I_WDATA : 8'h00)) | live;
    end
  end

  // Global summary and interrupt output
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      gstat_ff <= RST_ZERO;
      O_LINE_IRQ <= 1'b0;
    end else begin
      gstat_ff <= {7'h00, |(latch_ff & mask_ff)};
      O_LINE_IRQ <= gstat_ff[F_LIU_IRQ] && gmask_ff[F_LIU_IRQ];
    end
  end

  // Register read, one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      if (hit(I_ADDR, A_GXCVR_CTL2)) begin
        O_RDATA <= gxcvr_ff;
      end else if (hit(I_ADDR, A_GCLK_SEL)) begin
        O_RDATA <= gclk_ff;
      end else if (hit(I_ADDR, A_GIRQ_STAT)) begin
        O_RDATA <= gstat_ff;
      end else if (hit(I_ADDR, A_GIRQ_MASK)) begin
        O_RDATA <= gmask_ff;
      end else if (hit(I_ADDR, A_MODE_CTL)) begin
        O_RDATA <= mode_ff;
      end else if (hit(I_ADDR, A_TX_SHAPE)) begin
        O_RDATA <= shape_ff;
      end else if (hit(I_ADDR, A_MAINT_CTL)) begin
        O_RDATA <= maint_ff;
      end else if (hit(I_ADDR, A_LIVE_STAT)) begin
        O_RDATA <= live;
      end else if (hit(I_ADDR, A_STAT_MASK)) begin
        O_RDATA <= mask_ff;
      end else if (hit(I_ADDR, A_LATCH_STAT)) begin
        O_RDATA <= latch_ff;
      end else if (hit(I_ADDR, A_RX_LEVEL)) begin
        O_RDATA <= {4'h0, lvl_ff};
      end else if (hit(I_ADDR, A_RX_IMP_SENS)) begin
        O_RDATA <= rxcfg_ff;
      end else begin
        O_RDATA <= 8'h00;
      end
    end
  end

  // All-ones bit timing from the master clock; the rate is only
  // approximate since 10 MHz is no multiple of the line rate
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      acc_ff <= 16'h0000;
      ais_tick_ff <= 1'b0;
    end else begin
      {ais_tick_ff, acc_ff} <= {1'b0, acc_ff} + {1'b0, is_e1 ? E1_STEP : T1_STEP};
    end
  end

  // Coder: 8-symbol pipe; substitutions are decided on the oldest four slots in E1 and on all eight slots otherwise
  logic [1:0] nxt_pipe [8];
  always_comb begin
    nxt_pipe = pipe_ff;
    if (!mode_ff[F_AMI_SEL] && !ais) begin
      if (is_e1 && pipe_ff[7] == SYM_SPACE && pipe_ff[6] == SYM_SPACE &&
          pipe_ff[5] == SYM_SPACE && pipe_ff[4] == SYM_SPACE) begin
        nxt_pipe[7] = odd_ff ? SYM_SPACE : SYM_MARK;
        nxt_pipe[4] = SYM_VIOL;
      end else if (!is_e1 && pipe_ff[7] == SYM_SPACE && pipe_ff[6] == SYM_SPACE &&
          pipe_ff[5] == SYM_SPACE && pipe_ff[4] == SYM_SPACE &&
          pipe_ff[3] == SYM_SPACE && pipe_ff[2] == SYM_SPACE &&
          pipe_ff[1] == SYM_SPACE && pipe_ff[0] == SYM_SPACE) begin
        nxt_pipe[4] = SYM_VIOL;
        nxt_pipe[3] = SYM_MARK;
        nxt_pipe[1] = SYM_VIOL;
        nxt_pipe[0] = SYM_MARK;
      end
    end
  end

  // B00V and 000V patterns never re-trigger because their V is not a space
  wire [1:0] out_sym = nxt_pipe[7];
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < 8; i++) begin
        pipe_ff[i] <= SYM_SPACE;
      end
      last_pol_ff <= 1'b0;
      odd_ff <= 1'b0;
      code_ff <= '0;
    end else if (bit_en) begin
      pipe_ff[0] <= bit_in ? SYM_MARK : SYM_SPACE;
      for (int i = 1; i < 8; i++) begin
        pipe_ff[i] <= nxt_pipe[i-1];
      end
      if (out_sym == SYM_MARK) begin
        last_pol_ff <= !last_pol_ff;
        odd_ff <= !odd_ff;
        code_ff <= last_pol_ff ? '{pos: 1'b0, neg: 1'b1} : '{pos: 1'b1, neg: 1'b0};
      end else if (out_sym == SYM_VIOL) begin
        odd_ff <= 1'b0;
        code_ff <= last_pol_ff ? '{pos: 1'b1, neg: 1'b0} : '{pos: 1'b0, neg: 1'b1};
      end else begin
        code_ff <= '0;
      end
    end
  end

  // Attenuator stage, shared by transmit or receive path
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ja_ff <= '0;
      rx_d_ff <= 1'b0;
      rx_e_ff <= 1'b0;
      O_RX_DATA <= 1'b0;
      O_RX_BIT_EN <= 1'b0;
    end else begin
      if (bit_en) begin
        ja_ff <= code_ff;
      end
      rx_d_ff <= I_RX_DATA;
      rx_e_ff <= I_RX_BIT_EN;
      O_RX_DATA <= ja_rx ? rx_d_ff : I_RX_DATA;
      O_RX_BIT_EN <= ja_rx ? rx_e_ff : I_RX_BIT_EN;
    end
  end

  // Line driver; outputs held quiet while disabled or powered down
  wire drive = en_ff && !mode_ff[F_TRISTATE] && !maint_ff[F_TX_PDN];
  always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_TX_PULSE <= '0;
      O_TX_OE <= 1'b0;
      O_TX_PWR_DN <= 1'b0;
      O_TX_SHAPE <= 4'h0;
      O_TX_IMPED <= 2'h0;
      O_RX_CFG <= 8'h00;
    end else begin
      O_TX_OE <= drive;
      O_TX_PULSE <= drive ? (ja_tx ? ja_ff : code_ff) : '0;
      O_TX_PWR_DN <= maint_ff[F_TX_PDN];
      O_TX_SHAPE <= shape_ff[3:0];
      O_TX_IMPED <= shape_ff[5:4];
      O_RX_CFG <= rxcfg_ff;
    end
  end

  // Checks
  w1c_clear_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (wr_latch && I_WDATA[S_OPEN] && !live[S_OPEN] && !soft_rst_ff) |=> !latch_ff[S_OPEN])
    else $error("latched bit not cleared by write of one");
  set_wins_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    ev_ff[S_SHORT] |=> latch_ff[S_SHORT])
    else $error("latched bit lost an event");
  zero_write_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (wr_latch && !I_WDATA[S_LOS] && latch_ff[S_LOS] && !soft_rst_ff) |=> latch_ff[S_LOS])
    else $error("zero write changed latched bit");
  soft_tristate_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    mode_ff[F_TRISTATE] |=> !O_TX_OE && O_TX_PULSE == '0)
    else $error("outputs driven while tri-stated");
  pin_disable_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (!I_TX_OUTPUT_ENABLE_PIN [*3]) |=> !O_TX_OE)
    else $error("enable pin low but outputs driven");
  power_down_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    maint_ff[F_TX_PDN] |=> O_TX_PWR_DN && !O_TX_OE)
    else $error("power-down not applied");
  irq_gate_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (|(latch_ff & mask_ff)) && gmask_ff[F_LIU_IRQ] && !I_WR |-> ##2 O_LINE_IRQ)
    else $error("masked-in event did not raise interrupt");
  soft_reset_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (I_WR && hit(I_ADDR, A_SOFT_RST) && I_WDATA[F_LIU_RST]) |-> ##2 mode_ff == RST_ZERO)
    else $error("soft reset left mode register set");
  pulse_excl_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    !(O_TX_PULSE.pos && O_TX_PULSE.neg))
    else $error("both line polarities driven");
  viol_same_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (bit_en && out_sym == SYM_VIOL) |=> code_ff.pos == last_pol_ff && code_ff.neg != last_pol_ff)
    else $error("violation polarity wrong");
  // Attenuator placement on either path and the all-ones source
  ja_tx_path_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (drive && ja_tx) |=> O_TX_PULSE == $past(ja_ff))
    else $error("transmit attenuator path not taken");
  ja_bypass_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (drive && !ja_tx) |=> O_TX_PULSE == $past(code_ff))
    else $error("transmit attenuator not bypassed");
  rx_ja_path_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    ja_rx |=> O_RX_DATA == $past(rx_d_ff) && O_RX_BIT_EN == $past(rx_e_ff))
    else $error("receive attenuator path not taken");
  rx_bypass_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    !ja_rx |=> O_RX_DATA == $past(I_RX_DATA) && O_RX_BIT_EN == $past(I_RX_BIT_EN))
    else $error("receive attenuator not bypassed");
  ais_ones_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
    (ais && bit_en && !I_TX_NRZ) |=> pipe_ff[0] == SYM_MARK)
    else $error("framer data leaked into all ones");
endmodule
`default_nettype wire

// >>> dv/liu_line_model.sv
// Line model: decodes held transmit symbols at each framer bit enable.
// Assumes the bench commands fault and level conditions of the line.
`timescale 1ns/100ps
`default_nettype none
module liu_line_model
  import liu_pkg::*;
(
  // Symbol sampling
  input wire logic i_clk,
  input wire logic i_samp,
  input wire logic i_b8zs,
  input wire liu_pkg::liu_pulse_s i_pulse,
  // Line conditions
  input wire logic [2:0] i_fault,
  input wire logic [3:0] i_level,
  output logic [2:0] o_fault,
  output logic [3:0] o_level,
  // Decoded data, five symbols late so substitutions can be undone
  output logic o_vld = 1'b0,
  output logic o_bit = 1'b0,
  output int o_viol = 0,
  output int o_bad = 0
);
  logic [4:0] win = 5'h00;
  logic last_pos = 1'b0;
  logic seen = 1'b0;
  logic zap = 1'b0;
  logic m;
  logic v;
  assign o_fault = i_fault;
  assign o_level = i_level;
  always @(posedge i_clk) begin
    o_vld <= i_samp;
    if (i_samp) begin
      m = i_pulse.pos | i_pulse.neg;
      // A mark repeating the last polarity closes a substituted zero group
      v = m & seen & (i_pulse.pos == last_pos);
      o_bit <= win[4];
      win <= v ? {win[3], 4'h0} : {win[3:0], m & ~zap};
      // In the eight-zero code the mark after a violation is filler too
      zap = v & i_b8zs;
      if (m) begin
        seen = 1'b1;
        last_pos = i_pulse.pos;
      end
      if (v) o_viol <= o_viol + 1;
      if (i_pulse.pos & i_pulse.neg) o_bad <= o_bad + 1;
    end
  end
endmodule
`default_nettype wire

// >>> dv/line_interface_unit_control_test.sv
// Bench for the line interface control block: registers, output control,
// fault status, receive mux and transmit line coding.
// Assumes a 10 MHz clock; the line model decodes the transmitted symbols.
`timescale 1ns/100ps
`default_nettype none
module line_interface_unit_control_test;
  import liu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  liu_addr_t addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0, rd_s = 1'b0, tx_nrz = 1'b0, tx_en = 1'b0;
  logic rx_d = 1'b0, rx_en = 1'b0, pin = 1'b1, b8zs = 1'b0;
  logic [2:0] fault = 3'h0;
  logic [3:0] level = 4'h0;
  logic [7:0] rdata, rxcfg, d;
  logic o_rx_d, o_rx_en, oe, pdn, irq, dvld, dbit;
  logic [2:0] flt;
  logic [3:0] lvl, shape;
  logic [1:0] imped;
  liu_pulse_s pulse, pp;
  int viol, bad, v0, ch, sp;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h27CF02E7;
  int gap = 3;
  logic sent[$], dq[$], rxq[$];
  liu_addr_t cfg[5] = '{A_MODE_CTL, A_TX_SHAPE, A_MAINT_CTL, A_STAT_MASK, A_RX_IMP_SENS};
  logic [7:0] msk[5] = '{8'h3F, 8'h3F, 8'h1F, 8'h07, 8'hFF};
  logic [7:0] tmode[4] = '{8'h02, 8'h00, 8'h01, 8'h0A};
  logic [7:0] tmnt[4] = '{8'h00, 8'h18, 8'h08, 8'h00};

  always #50 clk = ~clk;

  liu_ctrl u_liu_ctrl (
    .I_MCLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
    .I_RD(rd_s), .O_RDATA(rdata), .I_TX_NRZ(tx_nrz), .I_TX_BIT_EN(tx_en),
    .I_RX_DATA(rx_d), .I_RX_BIT_EN(rx_en), .O_RX_DATA(o_rx_d), .O_RX_BIT_EN(o_rx_en),
    .I_TX_OUTPUT_ENABLE_PIN(pin), .I_SHORT_DET(flt[S_SHORT]), .I_OPEN_DET(flt[S_OPEN]),
    .I_RX_LOS(flt[S_LOS]), .I_RX_LEVEL(lvl), .O_TX_PULSE(pulse), .O_TX_OE(oe),
    .O_TX_PWR_DN(pdn), .O_TX_SHAPE(shape), .O_TX_IMPED(imped), .O_RX_CFG(rxcfg),
    .O_LINE_IRQ(irq)
  );

  liu_line_model u_liu_line_model (
    .i_clk(clk), .i_samp(tx_en), .i_b8zs(b8zs), .i_pulse(pulse), .i_fault(fault),
    .i_level(level), .o_fault(flt), .o_level(lvl), .o_vld(dvld), .o_bit(dbit),
    .o_viol(viol), .o_bad(bad)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input liu_addr_t a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rchk(input liu_addr_t a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    chk(rdata & m, e & m);
  endtask

  task automatic send(input int n, input bit rx, input bit z);
    logic b;
    repeat (n) begin
      b = z ? 1'b0 : 1'($random(seed));
      @(posedge clk);
      if (rx) begin
        rx_d <= b;
        rx_en <= 1'b1;
      end else begin
        tx_nrz <= b;
        tx_en <= 1'b1;
        sent.push_back(b);
      end
      @(posedge clk);
      rx_en <= 1'b0;
      tx_en <= 1'b0;
      cyc(gap);
    end
  endtask

  // The last symbols may belong to a group still in flight, so they are skipped
  task automatic cmp_seg();
    int n;
    while (sent.size() > 0 && sent[0] === 1'b0) void'(sent.pop_front());
    while (dq.size() > 0 && dq[0] === 1'b0) void'(dq.pop_front());
    n = (dq.size() < sent.size()) ? dq.size() : sent.size();
    chk(n > 60, 1'b1);
    for (int i = 0; i < n - 8; i++) chk(dq[i], sent[i]);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (dvld) dq.push_back(dbit);
    if (rx_en) rxq.push_back(rx_d);
    if (o_rx_en) begin
      if (rxq.size() == 0) chk(8'h01, 8'h00);
      else chk(o_rx_d, rxq.pop_front());
    end
  end

  initial begin
    cyc(20000);
    errors++;
    stop_test();
  end

  initial begin
    cyc(10);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rchk(cfg[i], msk[i], (i == 3) ? RST_MASK : RST_ZERO);
    rchk(13'h1008, 8'hFF, 8'h00);
    wr(A_LIVE_STAT, 8'hFF);
    rchk(A_LIVE_STAT, 8'h07, 8'h00);
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed)) & msk[i];
      if (i == 0) d[1:0] = 2'b10;
      wr(cfg[i], d);
      rchk(cfg[i], msk[i], d);
      if (i == 1) chk({imped, shape}, d[5:0]);
      if (i == 4) chk(rxcfg, d);
    end
    wr(A_SOFT_RST, 8'h01);
    cyc(3);
    for (int i = 0; i < 5; i++) rchk(cfg[i], msk[i], 8'h00);
    cyc(4);
    chk({oe, pdn}, 2'b10);
    pin <= 1'b0;
    cyc(5);
    chk(oe, 1'b0);
    pin <= 1'b1;
    wr(A_MODE_CTL, 8'h04);
    cyc(5);
    chk(oe, 1'b0);
    wr(A_MODE_CTL, 8'h00);
    wr(A_MAINT_CTL, 8'h04);
    cyc(2);
    chk(pdn, 1'b1);
    wr(A_MAINT_CTL, 8'h00);
    cyc(2);
    chk({oe, pdn}, 2'b10);
    wr(A_GIRQ_MASK, 8'h01);
    for (int b = 0; b < 3; b++) begin
      wr(A_STAT_MASK, (b == 1) ? 8'h00 : 8'(1 << b));
      fault <= 3'(1 << b);
      cyc(4);
      rchk(A_LIVE_STAT, 8'h07, 8'(1 << b));
      fault <= 3'h0;
      cyc(4);
      rchk(A_LIVE_STAT, 8'h07, 8'h00);
      rchk(A_LATCH_STAT, 8'h07, 8'(1 << b));
      chk(irq, b != 1);
      rchk(A_GIRQ_STAT, 8'h01, {7'h00, b != 1});
      wr(A_LATCH_STAT, 8'h00);
      rchk(A_LATCH_STAT, 8'h07, 8'(1 << b));
      wr(A_LATCH_STAT, 8'(1 << b));
      rchk(A_LATCH_STAT, 8'h07, 8'h00);
      cyc(3);
      chk(irq, 1'b0);
    end
    wr(A_GIRQ_MASK, 8'h00);
    fault <= 3'h4;
    cyc(6);
    chk(irq, 1'b0);
    wr(A_GIRQ_MASK, 8'h01);
    cyc(3);
    chk(irq, 1'b1);
    fault <= 3'h0;
    cyc(4);
    wr(A_LATCH_STAT, 8'h07);
    repeat (3) begin
      level <= 4'($random(seed));
      cyc(4);
      rchk(A_RX_LEVEL, 8'h0F, {4'h0, level});
    end
    wr(A_MAINT_CTL, 8'h08);
    send(30, 1, 0);
    cyc(40);
    wr(A_MAINT_CTL, 8'h00);
    send(30, 1, 0);
    cyc(40);
    chk(8'(rxq.size()), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(A_MODE_CTL, tmode[i]);
      wr(A_MAINT_CTL, tmnt[i]);
      b8zs <= tmode[i][1:0] != 2'b10 && !tmode[i][3];
      gap = (tmode[i][1:0] == 2'b10) ? 3 : 4;
      send(24, 0, 1);
      sent.delete();
      dq.delete();
      v0 = viol;
      send(40, 0, 0);
      send(8, 0, 1);
      send(40, 0, 0);
      send(24, 0, 1);
      chk(viol > v0, !tmode[i][3]);
      cmp_seg();
    end
    chk(8'(bad), 8'h00);
    // Forced all ones first, then all ones raised by loss of signal
    for (int k = 0; k < 2; k++) begin
      fault <= (k == 1) ? 3'h1 : 3'h0;
      wr(A_MAINT_CTL, (k == 1) ? 8'h02 : 8'h01);
      ch = 0;
      sp = 0;
      pp = pulse;
      fork
        send(40, 0, 1);
        begin
          cyc(60);
          repeat (100) begin
            @(posedge clk);
            if (pulse !== pp) ch++;
            if (pulse === 2'b00) sp++;
            pp = pulse;
          end
        end
      join
      chk(ch > 15, 1'b1);
      chk(8'(sp), 8'h00);
    end
    stop_test();
  end
endmodule
`default_nettype wire
